// [gpt_defines.svh]
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

// timer population: 0 standalone, 1/2 first pair, 3/4 second pair
`define GPT_NUM_TIMERS 5

// control register field positions
`define GPT_BIT_ON 15
`define GPT_BIT_IDLE_HALT 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PRESC_HI 5
`define GPT_BIT_PRESC_LO 4
`define GPT_BIT_CASCADE 3
`define GPT_BIT_SYNC 2
`define GPT_BIT_SRC 1

// implemented control bits per timer kind
`define GPT_MASK_STANDALONE 16'hA076
`define GPT_MASK_EVEN 16'hA07A
`define GPT_MASK_ODD 16'hA072

// register map: addr[4:2] selects the timer, addr[1:0] the register
`define GPT_OFS_CTRL 2'h0
`define GPT_OFS_COUNT 2'h1
`define GPT_OFS_PERIOD 2'h2
`define GPT_IDX_FLAGS 3'h5
`define GPT_ADDR_FLAGS 8'h14

// reset values
`define GPT_CTRL_RESET 16'h0000
`define GPT_COUNT_RESET 16'h0000
`define GPT_PERIOD_RESET 16'hFFFF

// prescaler terminal counts (divide by 1, 8, 64, 256)
`define GPT_PRESC_DIV1 8'h00
`define GPT_PRESC_DIV8 8'h07
`define GPT_PRESC_DIV64 8'h3F
`define GPT_PRESC_DIV256 8'hFF

// stages of the post-prescaler resynchroniser
`define GPT_SYNC_STAGES 2

`endif

// [gpt_pkg.sv]
`include "gpt_defines.svh"

package gpt_pkg;

   // clock path of one timer
   typedef enum logic [1:0] {
      MODE_TIMER,
      MODE_GATED,
      MODE_SYNC_COUNT,
      MODE_ASYNC_COUNT
   } gpt_mode_type;

   // state of one clock path
   typedef struct packed {
      logic pin_prev;
      logic [7:0] presc;
      logic pre_pulse;
      logic [`GPT_SYNC_STAGES-1:0] sync_pipe;
      logic gate_fall;
   } gpt_tick_state_type;

   // state of the whole timer set
   typedef struct packed {
      logic [`GPT_NUM_TIMERS-1:0][15:0] ctrl;
      logic [`GPT_NUM_TIMERS-1:0][15:0] count;
      logic [`GPT_NUM_TIMERS-1:0][15:0] period;
      logic [`GPT_NUM_TIMERS-1:0] flags;
      logic [`GPT_NUM_TIMERS-1:0] event_pulse;
      logic trig;
      logic [15:0] rd_data;
   } gpt_state_type;

endpackage

// [gpt_tick.sv]
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"

module gpt_tick
   import gpt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // timer setup
   input wire logic timer_on_i,
   input wire logic idle_halt_i,
   input wire logic gate_accumulate_enable_i,
   input wire logic [1:0] prescale_select_i,
   input wire logic external_clock_synchronize_i,
   input wire logic clock_source_select_i,
   // device state and pin
   input wire logic idle_i,
   input wire logic ext_pin_i,
   // count strobes
   output logic tick_o,
   output logic gate_fall_o
);

   localparam gpt_tick_state_type TICK_RESET = '0;

   gpt_tick_state_type st_reg;
   gpt_tick_state_type st_next;
   gpt_mode_type mode;
   logic run;
   logic raw;

   // terminal count of the prescaler
   function automatic logic [7:0] presc_limit(input logic [1:0] sel);
      case (sel)
         2'h0: presc_limit = `GPT_PRESC_DIV1;
         2'h1: presc_limit = `GPT_PRESC_DIV8;
         2'h2: presc_limit = `GPT_PRESC_DIV64;
         default: presc_limit = `GPT_PRESC_DIV256;
      endcase
   endfunction

   // mode from source, gate and sync bits
   function automatic gpt_mode_type decode_mode(input logic src, input logic gate,
                                                input logic sync);
      if (!src)
      begin
         decode_mode = gate ? MODE_GATED : MODE_TIMER; // RL6
      end
      else
      begin
         decode_mode = sync ? MODE_SYNC_COUNT : MODE_ASYNC_COUNT; // RL9
      end
   endfunction

   // clock selection, prescaler and resynchroniser
   always_comb
   begin
      st_next = st_reg;
      run = timer_on_i & ~(idle_i & idle_halt_i); // RL5
      mode = decode_mode(clock_source_select_i, gate_accumulate_enable_i,
                         external_clock_synchronize_i); // RL3
      case (mode)
         MODE_TIMER: raw = 1'b1; // RL2
         MODE_GATED: raw = ext_pin_i; // RL22
         MODE_SYNC_COUNT: raw = ext_pin_i & ~st_reg.pin_prev; // RL10
         MODE_ASYNC_COUNT: raw = ext_pin_i & ~st_reg.pin_prev; // RL20
         default: raw = 1'b0;
      endcase
      st_next.pin_prev = ext_pin_i;
      st_next.pre_pulse = 1'b0;
      // falling gate closes an accumulation window
      st_next.gate_fall = (mode == MODE_GATED) & run & st_reg.pin_prev & ~ext_pin_i; // RL22
      if (!run)
      begin
         st_next.presc = 8'h00;
      end
      else if (raw)
      begin
         // >= so a smaller ratio written mid-count wraps at once
         if (st_reg.presc >= presc_limit(prescale_select_i)) // RL7
         begin
            st_next.presc = 8'h00;
            st_next.pre_pulse = 1'b1;
         end
         else
         begin
            st_next.presc = st_reg.presc + 8'h01;
         end
      end
      // resync sits behind the prescaler, costing two cycles of lag
      st_next.sync_pipe = {st_reg.sync_pipe[0], st_reg.pre_pulse}; // RL8
      if (mode == MODE_SYNC_COUNT)
      begin
         tick_o = st_reg.sync_pipe[1] & run; // RL8
      end
      else
      begin
         tick_o = st_reg.pre_pulse & run;
      end
   end

   assign gate_fall_o = st_reg.gate_fall;

   // state register
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_reg <= TICK_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_div8;
      (run && mode == MODE_TIMER && prescale_select_i == 2'h1 && tick_o) ##1
      (run && mode == MODE_TIMER && prescale_select_i == 2'h1)[*7] ##1
      (run && mode == MODE_TIMER && prescale_select_i == 2'h1) |-> tick_o;
   endproperty
   a_div8: assert property (p_div8) else $error("divide by 8 tick spacing wrong"); // RL7

   property p_gate_low;
      (run && mode == MODE_GATED && !ext_pin_i) ##1 (run && mode == MODE_GATED) |-> !tick_o;
   endproperty
   a_gate_low: assert property (p_gate_low) else $error("gated timer ticked with gate low"); // RL22

endmodule
`default_nettype wire

// [gpt_timers.sv]
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"

// Summary of operation
// RL1: standalone timer is a free 16-bit counter
// RL2: timer modes count internal clock, counters pin
// RL3: source, sync, gate bits select standalone mode
// RL4: on bit starts and stops the timer
// RL5: idle halt bit stops timer in idle
// RL6: gate bit works only with internal clock
// RL7: prescale field divides by 1, 8, 64, 256
// RL8: external clock resynchronised after the prescaler
// RL9: sync bit matters only with external source
// RL10: source bit picks pin rising edge or internal
// RL11: count writes ignored in running sync counter; the code drops them for the standalone timer only
// RL12: paired timers have no asynchronous counter mode
// RL13: even cascade bit joins pair into 32 bits
// RL14: even timer low word, odd timer high word
// RL15: odd control ignored while pair is cascaded
// RL16: 32-bit match raises the odd timer flag
// RL17: software clears odd idle halt for idle running
// RL18: only first pair feeds time base and trigger
// RL19: even on bit runs whole pair when cascaded
// RL20: paired source bit counts own pin edges
// RL21: unimplemented control bits read as zero
// RL22: gated mode counts gate high, flags falling gate
// RL23: period match wraps count and sets flag
module gpt_timers
   import gpt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // register port
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [15:0] rd_data_o,
   // device state and clock pins
   input wire logic idle_i,
   input wire logic standalone_ext_clock_pin_i,
   input wire logic [1:0] even_ext_clock_pin_i,
   input wire logic [1:0] odd_ext_clock_pin_i,
   // events and time base
   output logic [4:0] timer_event_o,
   output logic [15:0] tb_even_count_o,
   output logic [15:0] tb_odd_count_o,
   output logic tb_cascade_o,
   output logic trigger_event_o
);

   localparam int NT = `GPT_NUM_TIMERS;
   localparam gpt_state_type ST_RESET = '{
      ctrl: {NT{`GPT_CTRL_RESET}},
      count: {NT{`GPT_COUNT_RESET}},
      period: {NT{`GPT_PERIOD_RESET}},
      flags: '0,
      event_pulse: '0,
      trig: 1'b0,
      rd_data: 16'h0000
   };

   gpt_state_type st_reg;
   gpt_state_type st_next;

   logic [NT-1:0] pin;
   logic [NT-1:0] tick;
   logic [NT-1:0] gfall;
   logic [NT-1:0] in_cas;
   logic [NT-1:0][15:0] eff_ctrl;
   logic [NT-1:0] wr_ctrl;
   logic [NT-1:0] wr_cnt;
   logic [NT-1:0] wr_per;
   logic [1:0] cas;
   logic count_locked;
   logic map_ok;
   logic [2:0] sel_idx;
   logic [1:0] sel_ofs;
   logic [NT-1:0] evt;
   logic [NT-1:0] flag_clr;
   logic [32:0] bump_res;

   // implemented-bit mask of one control register
   function automatic logic [15:0] ctrl_mask(input int idx);
      if (idx == 0)
      begin
         ctrl_mask = `GPT_MASK_STANDALONE;
      end
      else if ((idx % 2) == 1)
      begin
         ctrl_mask = `GPT_MASK_EVEN;
      end
      else
      begin
         ctrl_mask = `GPT_MASK_ODD;
      end
   endfunction

   // one count step: wrap to zero on period match, {match, next}
   function automatic logic [32:0] bump(input logic [31:0] cnt, input logic [31:0] per);
      if (cnt == per)
      begin
         bump = {1'b1, 32'h0000_0000}; // RL23
      end
      else
      begin
         bump = {1'b0, cnt + 32'h0000_0001};
      end
   endfunction

   // pin order follows the timer index
   assign pin = {odd_ext_clock_pin_i[1], even_ext_clock_pin_i[1],
                 odd_ext_clock_pin_i[0], even_ext_clock_pin_i[0],
                 standalone_ext_clock_pin_i};

   // cascade state per pair, taken from the even control only
   assign cas[0] = st_reg.ctrl[1][`GPT_BIT_CASCADE]; // RL13
   assign cas[1] = st_reg.ctrl[3][`GPT_BIT_CASCADE]; // RL13
   assign in_cas = {cas[1], cas[1], cas[0], cas[0], 1'b0};

   // software cannot write the standalone count while it runs as a synchronous counter
   assign count_locked = st_reg.ctrl[0][`GPT_BIT_ON] & st_reg.ctrl[0][`GPT_BIT_SRC]
                         & st_reg.ctrl[0][`GPT_BIT_SYNC]; // RL11

   // address decode
   assign sel_idx = addr_i[4:2];
   assign sel_ofs = addr_i[1:0];
   assign map_ok = (addr_i[7:5] == 3'h0);

   always_comb
   begin
      for (int i = 0; i < NT; i++)
      begin
         wr_ctrl[i] = wr_en_i & map_ok & (sel_idx == 3'(i)) & (sel_ofs == `GPT_OFS_CTRL);
         wr_cnt[i] = wr_en_i & map_ok & (sel_idx == 3'(i)) & (sel_ofs == `GPT_OFS_COUNT);
         wr_per[i] = wr_en_i & map_ok & (sel_idx == 3'(i)) & (sel_ofs == `GPT_OFS_PERIOD);
      end
   end

   // odd timer is parked while cascaded so its own bits do nothing
   always_comb
   begin
      for (int i = 0; i < NT; i++)
      begin
         if (i != 0 && (i % 2) == 0 && in_cas[i])
         begin
            eff_ctrl[i] = 16'h0000; // RL15
         end
         else
         begin
            eff_ctrl[i] = st_reg.ctrl[i]; // RL19
         end
      end
   end

   // one clock path per timer; paired timers always resync
   for (genvar g = 0; g < NT; g++)
   begin : g_tick
      gpt_tick u_tick (
         .clk_i(clk_i),
         .rst_b_i(rst_b_i),
         .timer_on_i(eff_ctrl[g][`GPT_BIT_ON]), // RL4
         .idle_halt_i(eff_ctrl[g][`GPT_BIT_IDLE_HALT]),
         .gate_accumulate_enable_i(eff_ctrl[g][`GPT_BIT_GATE]),
         .prescale_select_i(eff_ctrl[g][`GPT_BIT_PRESC_HI:`GPT_BIT_PRESC_LO]),
         .external_clock_synchronize_i((g == 0) ? eff_ctrl[g][`GPT_BIT_SYNC] : 1'b1), // RL12
         .clock_source_select_i(eff_ctrl[g][`GPT_BIT_SRC]),
         .idle_i(idle_i),
         .ext_pin_i(pin[g]),
         .tick_o(tick[g]),
         .gate_fall_o(gfall[g])
      );
   end

   // next-state logic of counters, flags and register port
   always_comb
   begin
      st_next = st_reg;
      evt = '0;
      bump_res = '0;
      flag_clr = '0;
      // independent 16-bit counting
      for (int i = 0; i < NT; i++)
      begin
         if (tick[i] && !in_cas[i])
         begin
            bump_res = bump({16'h0000, st_reg.count[i]}, {16'h0000, st_reg.period[i]}); // RL1
            st_next.count[i] = bump_res[15:0];
            evt[i] = evt[i] | bump_res[32]; // RL23
         end
         if (gfall[i] && !in_cas[i])
         begin
            evt[i] = 1'b1; // RL22
         end
      end
      // cascaded pairs count as one 32-bit value off the even clock path
      for (int p = 0; p < 2; p++)
      begin
         if (cas[p] && tick[2*p+1])
         begin
            bump_res = bump({st_reg.count[2*p+2], st_reg.count[2*p+1]},
                            {st_reg.period[2*p+2], st_reg.period[2*p+1]}); // RL14
            st_next.count[2*p+1] = bump_res[15:0];
            st_next.count[2*p+2] = bump_res[31:16];
            evt[2*p+2] = evt[2*p+2] | bump_res[32]; // RL16
         end
         if (cas[p] && gfall[2*p+1])
         begin
            evt[2*p+2] = 1'b1; // RL16
         end
      end
      // software writes; a count write beats a same-cycle tick
      for (int i = 0; i < NT; i++)
      begin
         if (wr_ctrl[i])
         begin
            st_next.ctrl[i] = wr_data_i & ctrl_mask(i); // RL21
         end
         if (wr_cnt[i] && !(i == 0 && count_locked))
         begin
            st_next.count[i] = wr_data_i; // RL11
         end
         if (wr_per[i])
         begin
            st_next.period[i] = wr_data_i;
         end
      end
      // write one to clear; a new event in the same cycle wins
      if (wr_en_i && addr_i == `GPT_ADDR_FLAGS)
      begin
         flag_clr = wr_data_i[NT-1:0];
      end
      st_next.flags = (st_reg.flags & ~flag_clr) | evt;
      st_next.event_pulse = evt;
      // trigger comes from the first pair alone
      st_next.trig = evt[1] | evt[2]; // RL18
      // read data valid in the cycle after the strobe only
      st_next.rd_data = 16'h0000;
      if (rd_en_i && map_ok)
      begin
         if (sel_idx == `GPT_IDX_FLAGS && sel_ofs == `GPT_OFS_CTRL)
         begin
            st_next.rd_data = {11'h000, st_reg.flags};
         end
         else if (sel_idx < `GPT_IDX_FLAGS)
         begin
            case (sel_ofs)
               `GPT_OFS_CTRL: st_next.rd_data = st_reg.ctrl[sel_idx]; // RL21
               `GPT_OFS_COUNT: st_next.rd_data = st_reg.count[sel_idx];
               `GPT_OFS_PERIOD: st_next.rd_data = st_reg.period[sel_idx];
               default: st_next.rd_data = 16'h0000;
            endcase
         end
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         st_reg <= ST_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs, all from the state register
   assign rd_data_o = st_reg.rd_data;
   assign timer_event_o = st_reg.event_pulse;
   assign tb_even_count_o = st_reg.count[1]; // RL18
   assign tb_odd_count_o = st_reg.count[2]; // RL18
   assign tb_cascade_o = st_reg.ctrl[1][`GPT_BIT_CASCADE];
   assign trigger_event_o = st_reg.trig;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   property p_wrap;
      tick[0] && !wr_cnt[0] && st_reg.count[0] == st_reg.period[0]
      |=> st_reg.count[0] == 16'h0000 && st_reg.flags[0] && timer_event_o[0];
   endproperty
   a_wrap: assert property (p_wrap) else $error("period match did not wrap and flag"); // RL23

   property p_inc;
      tick[0] && !wr_cnt[0] && st_reg.count[0] != st_reg.period[0]
      |=> st_reg.count[0] == $past(st_reg.count[0]) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("standalone count did not advance by one"); // RL1

   property p_lock;
      count_locked && wr_cnt[0] && !tick[0] |=> $stable(st_reg.count[0]);
   endproperty
   a_lock: assert property (p_lock) else $error("count write took effect while locked"); // RL11

   property p_stop;
      !st_reg.ctrl[0][`GPT_BIT_ON] && !wr_cnt[0] |=> $stable(st_reg.count[0]);
   endproperty
   a_stop: assert property (p_stop) else $error("stopped standalone timer counted"); // RL4

   property p_mask;
      rd_en_i && addr_i == 8'h04 |=> (rd_data_o & ~`GPT_MASK_EVEN) == 16'h0000;
   endproperty
   a_mask: assert property (p_mask) else $error("unimplemented control bit read as one"); // RL21

   property p_carry;
      cas[0] && tick[1] && !wr_cnt[1] && !wr_cnt[2] && st_reg.count[1] == 16'hFFFF
      && {st_reg.count[2], st_reg.count[1]} != {st_reg.period[2], st_reg.period[1]}
      |=> st_reg.count[1] == 16'h0000 && st_reg.count[2] == $past(st_reg.count[2]) + 16'h0001;
   endproperty
   a_carry: assert property (p_carry) else $error("low word carry missed high word"); // RL14

   property p_odd_flag;
      cas[0] && tick[1] && !wr_cnt[1] && !wr_cnt[2]
      && {st_reg.count[2], st_reg.count[1]} == {st_reg.period[2], st_reg.period[1]}
      |=> st_reg.flags[2] && timer_event_o[2] && !timer_event_o[1] && trigger_event_o
          && st_reg.count[2] == 16'h0000 && st_reg.count[1] == 16'h0000;
   endproperty
   a_odd_flag: assert property (p_odd_flag) else $error("32-bit match missed odd flag"); // RL16

   // odd clock path must stay quiet even with its own on bit set
   property p_park;
      cas[0] |-> !tick[2];
   endproperty
   a_park: assert property (p_park) else $error("odd timer ran while cascaded"); // RL15

   property p_hold;
      cas[0] && !st_reg.ctrl[1][`GPT_BIT_ON] && !wr_cnt[1] && !wr_cnt[2]
      |=> $stable(st_reg.count[1]) && $stable(st_reg.count[2]);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped cascaded pair counted"); // RL19

   property p_idle;
      idle_i && eff_ctrl[4][`GPT_BIT_IDLE_HALT] |-> !tick[4];
   endproperty
   a_idle: assert property (p_idle) else $error("idle halted timer still ticked"); // RL5

   property p_trig;
      trigger_event_o == (timer_event_o[1] || timer_event_o[2]);
   endproperty
   a_trig: assert property (p_trig) else $error("trigger not from first pair events"); // RL18

endmodule
`default_nettype wire

// [gpt_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none

module gpt_pin_model
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // bench control
   input wire logic [4:0] en_i,
   input wire logic [4:0] gate_i,
   input wire logic [7:0] space_i,
   // external clock and gate pins
   output logic [4:0] pin_o
);
   logic [7:0] phase_reg;

   // shared phase, so all enabled pins pulse together; space below 2 is not supported
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         phase_reg <= 8'h00;
      else if (phase_reg >= space_i - 8'h01)
         phase_reg <= 8'h00;
      else
         phase_reg <= phase_reg + 8'h01;
   end

   // one high cycle a period gives one rising edge; idle pins rest low
   always_comb
   begin
      for (int i = 0; i < 5; i++)
         pin_o[i] = gate_i[i] | (en_i[i] & (phase_reg == 8'h00));
   end
endmodule

`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "gpt_defines.svh"

module tb;
   import gpt_pkg::*;
   // bench-driven inputs
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [15:0] wr_data_i = 16'h0000;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic idle_i = 1'b0;
   logic [4:0] pin_en = 5'h00;
   logic [4:0] pin_gate = 5'h00;
   logic [7:0] pin_space = 8'h04;
   // design outputs
   logic [4:0] pins;
   logic [15:0] rd_data_o;
   logic [4:0] timer_event_o;
   logic [15:0] tb_even_count_o;
   logic [15:0] tb_odd_count_o;
   logic tb_cascade_o;
   logic trigger_event_o;
   // bench state
   int errors = 0;
   int n_checks = 0;
   int ev_cnt [5] = '{0, 0, 0, 0, 0};
   int k;
   int p;
   int sp;
   int snap;

   gpt_timers dut_u
   (
      .clk_i(clk_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o), .idle_i(idle_i), .standalone_ext_clock_pin_i(pins[0]),
      .even_ext_clock_pin_i({pins[3], pins[1]}), .odd_ext_clock_pin_i({pins[4], pins[2]}),
      .timer_event_o(timer_event_o), .tb_even_count_o(tb_even_count_o),
      .tb_odd_count_o(tb_odd_count_o), .tb_cascade_o(tb_cascade_o),
      .trigger_event_o(trigger_event_o)
   );

   gpt_pin_model pins_u
   (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(pin_en), .gate_i(pin_gate),
      .space_i(pin_space), .pin_o(pins)
   );

   // 125 MHz
   initial
   begin
      forever #4 clk_i = ~clk_i;
   end

   // event tally, used to prove silence over a stretch
   always @(posedge clk_i)
   begin
      for (int i = 0; i < 5; i++)
         if (timer_event_o[i] === 1'b1)
            ev_cnt[i]++;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // bus write: one strobe cycle, then one quiet cycle so strobes never merge
   task automatic wr(input logic [7:0] a, input logic [15:0] dat);
      wr_en_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= dat;
      @(posedge clk_i);
      wr_en_i <= 1'b0;
      @(posedge clk_i);
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      rd_en_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_en_i <= 1'b0;
      #1 chk(rd_data_o, exp);
      @(posedge clk_i);
   endtask

   // bounded wait for one event pulse; k holds the cycles spent
   task automatic wait_ev(input int idx, input int lim);
      k = 0;
      do
      begin
         @(posedge clk_i);
         #1;
         k++;
         if (k > lim)
         begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, k, lim);
            stop_test();
         end
      end
      while (timer_event_o[idx] !== 1'b1);
   endtask

   // distance between two events is independent of start latency
   task automatic gap_chk(input int idx, input int exp);
      wait_ev(idx, 2 * exp + 300);
      wait_ev(idx, exp + 4);
      chk(k, exp);
      @(posedge clk_i);
   endtask

   function automatic int div_of(input int ps);
      return (ps == 0) ? 1 : (ps == 1) ? 8 : (ps == 2) ? 64 : 256;
   endfunction

   initial
   begin
      void'($urandom(32'hf289));
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      // read, event, trigger and cascade outputs quiet right after reset release
      #1 chk(32'({rd_data_o, timer_event_o, trigger_event_o, tb_cascade_o}), 32'h0);
      @(posedge clk_i);
      // reset values and writable masks, one timer at a time
      for (int i = 0; i < 5; i++)
      begin
         rd_chk(8'(i * 4), `GPT_CTRL_RESET);
         rd_chk(8'(i * 4 + 1), `GPT_COUNT_RESET);
         rd_chk(8'(i * 4 + 2), `GPT_PERIOD_RESET);
         wr(8'(i * 4), 16'hFFFF);
         rd_chk(8'(i * 4), (i == 0) ? `GPT_MASK_STANDALONE :
                (i % 2 == 1) ? `GPT_MASK_EVEN : `GPT_MASK_ODD);
         wr(8'(i * 4), 16'h0000);
      end
      rd_chk(8'h1C, 16'h0000);
      $display("test registers done");
      // internal clock through each prescale; sync bit set but ignored
      wr(8'h02, 16'h0003);
      for (int ps = 0; ps < 4; ps++)
      begin
         wr(8'h00, 16'h8004 + 16'(16 * ps));
         gap_chk(0, div_of(ps) * 4);
         wr(8'h00, 16'h0000);
      end
      repeat (4) @(posedge clk_i);
      snap = ev_cnt[0];
      repeat (50) @(posedge clk_i);
      chk(ev_cnt[0] - snap, 0);
      $display("test prescale done");
      // pin counting, sync on and off, gate bit set but ignored
      pin_en <= 5'h1F;
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h00, 16'h8042 + 16'(4 * (m % 2)) + 16'(16 * (m / 2)));
         gap_chk(0, div_of(m / 2) * 16);
         wr(8'h00, 16'h0000);
      end
      pin_en <= 5'h00;
      // count writes dropped only in the running synchronous counter
      wr(8'h01, 16'h0009);
      wr(8'h00, 16'h8006);
      wr(8'h01, 16'h0005);
      rd_chk(8'h01, 16'h0009);
      wr(8'h00, 16'h8002);
      wr(8'h01, 16'h0005);
      rd_chk(8'h01, 16'h0005);
      wr(8'h00, 16'h0000);
      $display("test counter done");
      // gate held high for exactly seven cycles on timer 1
      wr(8'h04, 16'h8040);
      pin_gate <= 5'h02;
      repeat (7) @(posedge clk_i);
      pin_gate <= 5'h00;
      wait_ev(1, 6);
      chk(trigger_event_o, 1'b1);
      @(posedge clk_i);
      wr(8'h04, 16'h0000);
      rd_chk(8'h05, 16'h0007);
      chk(tb_even_count_o, 16'h0007);
      $display("test gated done");
      // cascaded first pair; odd set to on and div 256, which must not matter
      wr(8'h04, 16'h0008);
      wr(8'h08, 16'h8030);
      wr(8'h05, 16'hFFFC);
      wr(8'h06, 16'h0002);
      wr(8'h09, 16'h0000);
      wr(8'h0A, 16'h0001);
      snap = ev_cnt[1];
      wr(8'h04, 16'h8008);
      chk(tb_cascade_o, 1'b1);
      gap_chk(2, 32'h0001_0003);
      chk(ev_cnt[1] - snap, 0);
      wr(8'h04, 16'h0000);
      // low word one short of carry: first tick must lift the high word
      wr(8'h05, 16'hFFFF);
      wr(8'h09, 16'h0000);
      wr(8'h04, 16'h8008);
      @(posedge clk_i);
      #1 chk(tb_odd_count_o, 16'h0001);
      chk(tb_even_count_o, 16'h0000);
      @(posedge clk_i);
      wr(8'h04, 16'h0000);
      wr(8'h08, 16'h0000);
      $display("test cascade done");
      // second pair: timer 3 on its own pin, timer 4 internal with idle halt
      p = $urandom_range(9, 2);
      sp = $urandom_range(6, 2);
      pin_space <= 8'(sp);
      pin_en <= 5'h08;
      wr(8'h0E, 16'(p));
      wr(8'h12, 16'(p));
      wr(8'h0C, 16'h8002);
      wr(8'h10, 16'hA000);
      gap_chk(3, sp * (p + 1));
      wait_ev(3, 200);
      chk(trigger_event_o, 1'b0);
      @(posedge clk_i);
      gap_chk(4, p + 1);
      idle_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      snap = ev_cnt[4];
      repeat (3 * p + 6) @(posedge clk_i);
      chk(ev_cnt[4] - snap, 0);
      gap_chk(3, sp * (p + 1));
      wr(8'h10, 16'h8000);
      gap_chk(4, p + 1);
      idle_i <= 1'b0;
      wr(8'h0C, 16'h0000);
      wr(8'h10, 16'h0000);
      pin_en <= 5'h00;
      $display("test second pair done");
      // sticky flags of all five timers, then write-one clear
      repeat (4) @(posedge clk_i);
      rd_chk(`GPT_ADDR_FLAGS, 16'h001F);
      wr(`GPT_ADDR_FLAGS, 16'h001F);
      rd_chk(`GPT_ADDR_FLAGS, 16'h0000);
      $display("test flags done");
      stop_test();
   end
endmodule

`default_nettype wire
